// File: src/execute_stage_timing_consts.svh
// Constants for the execute-stage timing block: widths, register file size and stall length.
`ifndef EXECUTE_STAGE_TIMING_CONSTS_SVH
`define EXECUTE_STAGE_TIMING_CONSTS_SVH
`define EST_DATA_W 32
`define EST_REG_IDX_W 5
`define EST_NUM_REGS 32
`define EST_MEM_LANES 2
`define EST_SPAN_STALL_CYCLES 1
`define EST_HALF_W 16
`endif

// File: src/execute_stage_timing_pkg.sv
// Types shared by the execute-stage timing block and its users.
package execute_stage_timing_pkg;
  // Class of the instruction on the compute lane of an execute packet.
  typedef enum logic [2:0] {OP_NONE, OP_SINGLE, OP_MUL, OP_MUNIT, OP_XMUL, OP_BRANCH} op_e;
  // Class of the instruction on one memory lane of an execute packet.
  typedef enum logic [1:0] {MEM_NONE, MEM_LOAD, MEM_STORE} mem_e;
  typedef struct packed {
    op_e op;
    logic cond;
    logic [4:0] dst;
    logic [4:0] first_source_operand;
    logic [4:0] second_source_operand;
    logic [31:0] target;
    logic target_spans;
  } compute_s;
  typedef struct packed {
    mem_e kind;
    logic cond;
    logic [4:0] base_pointer_register;
    logic [31:0] offset_operand;
    logic pre_modify;
    logic update_base;
    logic [4:0] data_reg;
  } memop_s;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] data;
  } mem_req_s;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } fetch_redirect_s;
endpackage : execute_stage_timing_pkg

// File: src/execute_stage_timing.sv
// Execute phases one to five: operand reads, result write-back, memory requests and branch redirects.
`timescale 1ns/1ps
`include "execute_stage_timing_consts.svh"

module execute_stage_timing #(
  parameter int DATA_W = `EST_DATA_W,
  parameter int NUM_REGS = `EST_NUM_REGS,
  parameter int MEM_LANES = `EST_MEM_LANES,
  parameter bit ENHANCED = 1'b1
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_in,
  // Decoded execute packet, presented during its unit_decode cycle.
  input wire logic issue_valid_in,
  input wire execute_stage_timing_pkg::compute_s compute_in,
  input wire execute_stage_timing_pkg::memop_s [MEM_LANES-1:0] memop_in,
  // Return from interrupt or exception.
  input wire logic irq_return_in,
  input wire logic irq_return_spans_in,
  // Load data at the core boundary during execute_phase_four.
  input wire logic [MEM_LANES-1:0][31:0] load_data_in,
  // Register observation port.
  input wire logic [4:0] peek_addr_in,
  // Data memory requests, standing during execute_phase_two.
  output execute_stage_timing_pkg::mem_req_s [MEM_LANES-1:0] mem_req_out,
  // Fetch redirect during the branch's execute_phase_one and the spanning stall.
  output execute_stage_timing_pkg::fetch_redirect_s fetch_redirect_out,
  output logic fetch_stall_out,
  // Register observation data.
  output logic [31:0] peek_data_out
);

  localparam int HW = `EST_HALF_W;

  // Refuse settings the fixed struct widths cannot carry.
  if (DATA_W != `EST_DATA_W || NUM_REGS < 1 || NUM_REGS > (1 << `EST_REG_IDX_W) || MEM_LANES < 1)
  begin : g_bad_params
    $error("execute_stage_timing: unsupported parameter set");
  end

  // True for a memory lane of the given kind whose condition holds.
  function automatic logic lane_is(input execute_stage_timing_pkg::memop_s m,
                                   input execute_stage_timing_pkg::mem_e k);
    lane_is = (m.kind == k) && m.cond;
  endfunction : lane_is

  logic [31:0] regs [NUM_REGS];

  // Compute lane stages: phase one holds the packet, later stages hold results in flight.
  logic c1_valid;
  execute_stage_timing_pkg::compute_s c1;
  logic c2_valid;
  logic [4:0] c2_dst;
  logic [31:0] c2_res;
  logic [2:0] x_valid;
  logic [4:0] x_dst [3];
  logic [31:0] x_res [3];

  // Memory lane stages.
  logic [MEM_LANES-1:0] m1_valid;
  execute_stage_timing_pkg::memop_s [MEM_LANES-1:0] m1;
  logic [MEM_LANES-1:0] ld3_valid;
  logic [MEM_LANES-1:0] ld4_valid;
  logic [MEM_LANES-1:0] ld5_valid;
  logic [4:0] ld2_dst [MEM_LANES];
  logic [4:0] ld3_dst [MEM_LANES];
  logic [4:0] ld4_dst [MEM_LANES];
  logic [4:0] ld5_dst [MEM_LANES];
  logic [31:0] ld5_data [MEM_LANES];

  // Phase-one operand values, read straight from the register file.
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [32:0] avg_sum;
  logic [31:0] next_single;
  logic [31:0] next_mul;
  logic [31:0] next_munit;
  logic [31:0] next_xmul;
  logic c1_live;

  // no interlock: operands are whatever the file holds now.
  assign op_a = regs[c1.first_source_operand];
  assign op_b = regs[c1.second_source_operand];
  // condition gate: a false packet stops here.
  assign c1_live = c1_valid && c1.cond;
  assign avg_sum = {1'b0, op_a} + {1'b0, op_b};
  assign next_single = op_a + op_b;
  // multiply start: 16x16 product begins in phase one.
  assign next_mul = op_a[HW-1:0] * op_b[HW-1:0];
  // non-multiply: truncated average uses the multiply unit timing.
  assign next_munit = avg_sum[32:1];
  // extended start: both half products start in phase one.
  assign next_xmul = (op_a[HW-1:0] * op_b[HW-1:0]) + (op_a[31:HW] * op_b[31:HW]);

  // Packet enters execute_phase_one.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      c1_valid <= 1'b0;
      c1 <= '0;
      m1_valid <= '0;
      m1 <= '0;
    end
    else
    begin
      c1_valid <= issue_valid_in;
      c1 <= compute_in;
      m1_valid <= {MEM_LANES{issue_valid_in}};
      m1 <= memop_in;
    end
  end

  // Two-phase results: multiply and multiply-unit operations.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      c2_valid <= 1'b0;
      c2_dst <= '0;
      c2_res <= '0;
    end
    else
    begin
      // same path: both classes land in phase two.
      c2_valid <= c1_live && (c1.op == execute_stage_timing_pkg::OP_MUL ||
                              c1.op == execute_stage_timing_pkg::OP_MUNIT);
      c2_dst <= c1.dst;
      c2_res <= (c1.op == execute_stage_timing_pkg::OP_MUL) ? next_mul : next_munit;
    end
  end

  // Extended multiply result carried through phases two to four.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      x_valid <= '0;
      for (int i = 0; i < 3; i++)
      begin
        x_dst[i] <= '0;
        x_res[i] <= '0;
      end
    end
    else
    begin
      x_valid <= {x_valid[1:0], c1_live && c1.op == execute_stage_timing_pkg::OP_XMUL};
      x_dst[0] <= c1.dst;
      x_res[0] <= next_xmul;
      for (int i = 1; i < 3; i++)
      begin
        x_dst[i] <= x_dst[i-1];
        x_res[i] <= x_res[i-1];
      end
    end
  end

  // One memory lane per generate pass: requests, load tracking and data capture.
  for (genvar g = 0; g < MEM_LANES; g++)
  begin : g_lane
    logic [31:0] base_val;
    logic [31:0] moved;
    logic lane_ld;
    logic lane_st;
    assign base_val = regs[m1[g].base_pointer_register];
    assign moved = base_val + m1[g].offset_operand;
    assign lane_ld = m1_valid[g] && lane_is(m1[g], execute_stage_timing_pkg::MEM_LOAD);
    assign lane_st = m1_valid[g] && lane_is(m1[g], execute_stage_timing_pkg::MEM_STORE);

    // Request stands during execute_phase_two; lanes go out together and in issue order.
    always_ff @(posedge mclk_in)
    begin
      if (reset_in)
      begin
        mem_req_out[g] <= '0;
      end
      else
      begin
        // store send: address and data face memory in phase two.
        // load send: address goes to memory in phase two.
        // ordering: requests leave strictly in packet order.
        // ordering: a store one packet ahead reaches memory one cycle earlier.
        // same packet: load and store share the cycle; memory reads first.
        // store visibility: equal depth to memory for loads and stores.
        mem_req_out[g].valid <= lane_ld || lane_st;
        mem_req_out[g].write <= lane_st;
        mem_req_out[g].addr <= m1[g].pre_modify ? moved : base_val;
        mem_req_out[g].data <= regs[m1[g].data_reg];
      end
    end

    // Load destination tracked through phases three to five.
    always_ff @(posedge mclk_in)
    begin
      if (reset_in)
      begin
        ld3_valid[g] <= 1'b0;
        ld4_valid[g] <= 1'b0;
        ld5_valid[g] <= 1'b0;
        ld2_dst[g] <= '0;
        ld3_dst[g] <= '0;
        ld4_dst[g] <= '0;
        ld5_dst[g] <= '0;
        ld5_data[g] <= '0;
      end
      else
      begin
        ld3_valid[g] <= mem_req_out[g].valid && !mem_req_out[g].write;
        ld4_valid[g] <= ld3_valid[g];
        ld5_valid[g] <= ld4_valid[g];
        ld2_dst[g] <= m1[g].data_reg;
        ld3_dst[g] <= ld2_dst[g];
        ld4_dst[g] <= ld3_dst[g];
        ld5_dst[g] <= ld4_dst[g];
        // data capture: boundary data sampled in phase four.
        ld5_data[g] <= load_data_in[g];
      end
    end
  end

  // Register file writes. Older packets are written first so a younger write to the same register wins.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      for (int r = 0; r < NUM_REGS; r++)
      begin
        regs[r] <= '0;
      end
    end
    else
    begin
      for (int l = 0; l < MEM_LANES; l++)
      begin
        // load write: data lands at end of phase five.
        if (ld5_valid[l])
        begin
          regs[ld5_dst[l]] <= ld5_data[l];
        end
      end
      // extended write: end of phase four, three slots.
      if (x_valid[2])
      begin
        regs[x_dst[2]] <= x_res[2];
      end
      // multiply write: end of phase two, one slot.
      if (c2_valid)
      begin
        regs[c2_dst] <= c2_res;
      end
      // single cycle: written at end of phase one.
      if (c1_live && c1.op == execute_stage_timing_pkg::OP_SINGLE)
      begin
        regs[c1.dst] <= next_single;
      end
      for (int l = 0; l < MEM_LANES; l++)
      begin
        // pointer write: base updated in phase one.
        // pointer visible: next packet reads the new base.
        // no store slots: nothing of a store reaches a register later.
        if (m1_valid[l] && m1[l].cond && m1[l].kind != execute_stage_timing_pkg::MEM_NONE && m1[l].update_base)
        begin
          regs[m1[l].base_pointer_register] <= regs[m1[l].base_pointer_register] + m1[l].offset_operand;
        end
      end
    end
  end

  // Branch redirect: set from the decoded packet so it stands during the branch's phase one.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      fetch_redirect_out <= '0;
    end
    else
    begin
      // target to generate: redirect shown in the branch's phase one.
      // five slots: target then needs five more phases before its phase one.
      fetch_redirect_out.valid <= issue_valid_in && compute_in.cond &&
                                  compute_in.op == execute_stage_timing_pkg::OP_BRANCH;
      fetch_redirect_out.addr <= compute_in.target;
    end
  end

  // Spanning-target stall. Only one stall cycle is requested; the fetch side owns the hold itself.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      fetch_stall_out <= 1'b0;
    end
    else
    begin
      // span stall: branch target crossing fetch packets.
      // return stall: interrupt return to a spanning packet.
      fetch_stall_out <= ENHANCED && ((c1_live && c1.op == execute_stage_timing_pkg::OP_BRANCH && c1.target_spans) ||
                                      (irq_return_in && irq_return_spans_in));
    end
  end

  // Registered view of one register, for observation.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      peek_data_out <= '0;
    end
    else
    begin
      peek_data_out <= regs[peek_addr_in];
    end
  end

endmodule : execute_stage_timing

// File: sim/execute_stage_timing_assertions.sv
// Concurrent checks on the ports of the execute-stage timing block.
`timescale 1ns/1ps
module execute_stage_timing_checker #(
  parameter int MEM_LANES = 2,
  parameter bit ENHANCED = 1'b1
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_in,
  // Issue side.
  input wire logic issue_valid_in,
  input wire execute_stage_timing_pkg::compute_s compute_in,
  input wire execute_stage_timing_pkg::memop_s [MEM_LANES-1:0] memop_in,
  input wire logic irq_return_in,
  input wire logic irq_return_spans_in,
  // Memory and fetch side.
  input wire execute_stage_timing_pkg::mem_req_s [MEM_LANES-1:0] mem_req_out,
  input wire execute_stage_timing_pkg::fetch_redirect_s fetch_redirect_out,
  input wire logic fetch_stall_out
);
  logic br;
  logic ld0;
  logic st0;
  logic any1;
  // Decoded causes; only lanes with a true condition count.
  assign br = issue_valid_in && compute_in.op == execute_stage_timing_pkg::OP_BRANCH && compute_in.cond;
  assign ld0 = issue_valid_in && memop_in[0].cond && memop_in[0].kind == execute_stage_timing_pkg::MEM_LOAD;
  assign st0 = issue_valid_in && memop_in[0].cond && memop_in[0].kind == execute_stage_timing_pkg::MEM_STORE;
  assign any1 = issue_valid_in && memop_in[1].cond && memop_in[1].kind != execute_stage_timing_pkg::MEM_NONE;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  a_branch_redirect: assert property (br |=> fetch_redirect_out.valid && fetch_redirect_out.addr == $past(compute_in.target))
    else $error("redirect missing or wrong after a branch");
  a_redirect_cause: assert property (fetch_redirect_out.valid |-> $past(br))
    else $error("redirect without a taken branch");
  a_span_stall: assert property (br && compute_in.target_spans && ENHANCED |-> ##2 fetch_stall_out)
    else $error("no stall for a spanning branch target");
  a_return_stall: assert property (irq_return_in && irq_return_spans_in && ENHANCED |=> fetch_stall_out)
    else $error("no stall for a spanning return target");
  a_stall_cause: assert property (fetch_stall_out |-> $past(irq_return_in && irq_return_spans_in) || $past(br && compute_in.target_spans, 2))
    else $error("stall without a spanning target");
  a_store_request: assert property (st0 |-> ##2 mem_req_out[0].valid && mem_req_out[0].write)
    else $error("store request not in phase two");
  a_load_request: assert property (ld0 |-> ##2 mem_req_out[0].valid && !mem_req_out[0].write)
    else $error("load request not in phase two");
  a_false_quiet: assert property (issue_valid_in && memop_in[0].kind != execute_stage_timing_pkg::MEM_NONE && !memop_in[0].cond |-> ##2 !mem_req_out[0].valid)
    else $error("request from a false-condition lane");
  a_request_cause: assert property (mem_req_out[0].valid |-> $past(ld0 || st0, 2))
    else $error("request without an issued memory lane");
  a_lane_pair: assert property (any1 |-> ##2 mem_req_out[1].valid)
    else $error("second lane request missing in phase two");
  cover property (br ##1 fetch_redirect_out.valid);
  cover property (fetch_stall_out);
  cover property (mem_req_out[0].valid && mem_req_out[0].write);
  cover property (mem_req_out[0].valid && mem_req_out[1].valid);
endmodule : execute_stage_timing_checker

bind execute_stage_timing execute_stage_timing_checker #(.MEM_LANES(MEM_LANES), .ENHANCED(ENHANCED))
  execute_stage_timing_checker_i (.mclk_in, .reset_in, .issue_valid_in, .compute_in, .memop_in, .irq_return_in,
  .irq_return_spans_in, .mem_req_out, .fetch_redirect_out, .fetch_stall_out);

// File: sim/data_memory_model.sv
// Behavioural data memory answering the execute stage's requests.
`timescale 1ns/1ps
module data_memory_model #(
  parameter int MEM_LANES = 2
) (
  // Clock.
  input wire logic mclk_in,
  // Requests in and read data out.
  input wire execute_stage_timing_pkg::mem_req_s [MEM_LANES-1:0] mem_req_in,
  output logic [MEM_LANES-1:0][31:0] load_data_out
);
  logic [31:0] mem [64];
  execute_stage_timing_pkg::mem_req_s [MEM_LANES-1:0] access;
  logic [MEM_LANES-1:0][31:0] rdata = '0;
  logic [MEM_LANES-1:0] back = '0;
  // Known contents so the bench can predict old values.
  initial for (int i = 0; i < 64; i++) mem[i] = 32'hc0de0000 + i;
  always @(posedge mclk_in) access <= mem_req_in;
  // Reads use the contents before any write at the same edge, so a same-packet load sees old data.
  // read before write
  always @(posedge mclk_in)
  begin
    for (int l = 0; l < MEM_LANES; l++)
      rdata[l] <= mem[access[l].addr[7:2]];
    for (int l = 0; l < MEM_LANES; l++)
      back[l] <= access[l].valid && !access[l].write;
    for (int l = 0; l < MEM_LANES; l++)
      if (access[l].valid && access[l].write)
        mem[access[l].addr[7:2]] = access[l].data;
  end
  // Outside phase four the lines carry inverted data, never a stale copy.
  // data at boundary
  always_comb
    for (int l = 0; l < MEM_LANES; l++)
      load_data_out[l] = back[l] ? rdata[l] : ~rdata[l];
endmodule : data_memory_model

// File: sim/testbench.sv
// Self-checking bench for the execute-stage timing block.
`timescale 1ns/1ps
module testbench;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic issue_valid_in = 1'b0;
  execute_stage_timing_pkg::compute_s compute_in = '0;
  execute_stage_timing_pkg::memop_s [1:0] memop_in = '0;
  logic irq_return_in = 1'b0;
  logic irq_return_spans_in = 1'b0;
  logic [1:0][31:0] load_data_in;
  logic [4:0] peek_addr_in = '0;
  execute_stage_timing_pkg::mem_req_s [1:0] mem_req_out;
  execute_stage_timing_pkg::fetch_redirect_s fetch_redirect_out;
  logic fetch_stall_out;
  logic [31:0] peek_data_out;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  execute_stage_timing #(.MEM_LANES(2)) execute_stage_timing_i (.mclk_in, .reset_in, .issue_valid_in, .compute_in,
    .memop_in, .irq_return_in, .irq_return_spans_in, .load_data_in, .peek_addr_in, .mem_req_out,
    .fetch_redirect_out, .fetch_stall_out, .peek_data_out);
  data_memory_model #(.MEM_LANES(2)) data_memory_model_i (.mclk_in, .mem_req_in(mem_req_out),
    .load_data_out(load_data_in));
  // Clock and hang guard; the run needs well under a thousand cycles.
  initial forever #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input logic [165:0] got, input logic [165:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic execute_stage_timing_pkg::compute_s cp(execute_stage_timing_pkg::op_e op, logic c,
    logic [4:0] d, logic [31:0] t, logic sp);
    return '{op, c, d, 5'h01, 5'h02, t, sp};
  endfunction : cp
  function automatic execute_stage_timing_pkg::memop_s mo(logic st, logic c, logic [4:0] b, logic [31:0] off,
    logic pm, logic ub, logic [4:0] r);
    return '{st ? execute_stage_timing_pkg::MEM_STORE : execute_stage_timing_pkg::MEM_LOAD, c, b, off, pm, ub, r};
  endfunction : mo
  // Packets are held for one edge; the caller ends a burst with idle so no signal is set twice in a step.
  task automatic send(input execute_stage_timing_pkg::compute_s c, input execute_stage_timing_pkg::memop_s a,
    input execute_stage_timing_pkg::memop_s b);
    issue_valid_in = 1'b1;
    compute_in = c;
    memop_in = {b, a};
    @(posedge mclk_in);
    #1;
  endtask : send
  task automatic idle();
    issue_valid_in = 1'b0;
    compute_in = '0;
    memop_in = '0;
  endtask : idle
  task automatic peek(input logic [4:0] r, input logic [31:0] exp);
    peek_addr_in = r;
    @(posedge mclk_in);
    #1;
    chk(peek_data_out, exp);
  endtask : peek
  // Old value in the last delay slot, new value one packet later.
  task automatic watch(input logic [4:0] r, input int n, input logic [31:0] oldv, input logic [31:0] newv);
    idle();
    peek_addr_in = r;
    repeat (n) @(posedge mclk_in);
    #1;
    chk(peek_data_out, oldv);
    @(posedge mclk_in);
    #1;
    chk(peek_data_out, newv);
  endtask : watch
  task automatic t_pointers();
    send('0, mo(0, 1, 5'h01, 32'h4, 0, 1, 5'h14), mo(0, 1, 5'h02, 32'h8, 0, 1, 5'h15));
    watch(5'h01, 1, 32'h0, 32'h4);
    send('0, mo(1, 1, 5'h0c, 32'h10, 0, 1, 5'h03), '0);
    watch(5'h0c, 1, 32'h0, 32'h10);
  endtask : t_pointers
  task automatic t_load();
    send('0, mo(0, 1, 5'h02, 32'h4, 1, 0, 5'h07), '0);
    watch(5'h07, 5, 32'h0, 32'hc0de0003);
  endtask : t_load
  task automatic t_compute();
    execute_stage_timing_pkg::op_e ops[4] = '{execute_stage_timing_pkg::OP_MUL, execute_stage_timing_pkg::OP_MUNIT,
      execute_stage_timing_pkg::OP_XMUL, execute_stage_timing_pkg::OP_SINGLE};
    int lat[4] = '{2, 2, 4, 1};
    logic [31:0] res[4] = '{32'h20, 32'h6, 32'h20, 32'hc};
    for (int i = 0; i < 4; i++)
    begin
      send(cp(ops[i], 1, 5'(3 + i), 32'h0, 0), '0, '0);
      watch(5'(3 + i), lat[i], 32'h0, res[i]);
    end
  endtask : t_compute
  task automatic t_false();
    send(cp(execute_stage_timing_pkg::OP_MUL, 0, 5'h03, 32'h0, 0), mo(0, 0, 5'h01, 32'h4, 0, 1, 5'h09), '0);
    watch(5'h03, 2, 32'h20, 32'h20);
    peek(5'h01, 32'h4);
  endtask : t_false
  task automatic t_order();
    send('0, mo(0, 1, 5'h01, 32'h0, 0, 0, 5'h08), '0);
    send('0, mo(1, 1, 5'h01, 32'h0, 0, 0, 5'h03), '0);
    send('0, mo(0, 1, 5'h01, 32'h0, 0, 0, 5'h09), '0);
    chk(mem_req_out[0], {1'b1, 1'b1, 32'h4, 32'h20});
    send('0, mo(0, 1, 5'h01, 32'h0, 0, 0, 5'h0a), mo(1, 1, 5'h01, 32'h0, 0, 0, 5'h04));
    send('0, mo(0, 1, 5'h01, 32'h0, 0, 0, 5'h0b), '0);
    chk(mem_req_out[1], {1'b1, 1'b1, 32'h4, 32'h6});
    idle();
    repeat (5) @(posedge mclk_in);
    #1;
    peek(5'h08, 32'hc0de0001);
    peek(5'h09, 32'h20);
    peek(5'h0a, 32'h20);
    peek(5'h0b, 32'h6);
  endtask : t_order
  task automatic t_branch();
    for (int i = 0; i < 3; i++)
    begin
      send(cp(execute_stage_timing_pkg::OP_BRANCH, i != 0, 5'h00, 32'h100 + i, i == 2), '0, '0);
      idle();
      chk(fetch_redirect_out, {i != 0, 32'h100 + i});
      @(posedge mclk_in);
      #1;
      chk(fetch_stall_out, i == 2);
    end
  endtask : t_branch
  task automatic t_return();
    for (int s = 0; s < 2; s++)
    begin
      irq_return_in = 1'b1;
      irq_return_spans_in = s[0];
      @(posedge mclk_in);
      #1;
      irq_return_in = 1'b0;
      chk(fetch_stall_out, s[0]);
      @(posedge mclk_in);
      #1;
    end
  endtask : t_return
  // Main sequence: reset for three cycles, then each scenario in turn.
  initial
  begin
    repeat (3) @(posedge mclk_in);
    #1;
    reset_in = 1'b0;
    chk({mem_req_out, fetch_redirect_out, fetch_stall_out}, '0);
    t_pointers();
    t_load();
    t_compute();
    t_false();
    t_order();
    t_branch();
    t_return();
    close_out();
  end
endmodule : testbench
